//--- logic/clk_ctl_pkg.sv
/*
  Shared constants for the loop clock control block: register index and
  byte address, field positions, reset values and divider encodings.
  Assumes a 32-bit APB bus with a 12-bit byte address.
*/
package clk_ctl_pkg;
  // register index as printed; byte address is four times it
  localparam logic [9:0] CTRL_INDEX = 10'h0D7;
  localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [7:0] CTRL_RESET = 8'h03;
  // field positions
  localparam int OSC_HALT_BIT = 7;
  localparam int LOCK_BIT = 6;
  localparam int LATCHED_PIN_BIT = 4;
  localparam int FAST_IRQ_BIT = 3;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  // divider codes
  localparam logic [2:0] DIV_DEFAULT = 3'h3;
  localparam logic [2:0] DIV_FAST = 3'h0;
  // loop clock to crystal ratio; counter counts 0 to ratio-1
  localparam logic [8:0] MOD_RATIO = 9'h180;
  localparam logic [8:0] MOD_LAST = MOD_RATIO - 9'h001;
  localparam int PHASE_W = 7;

  // loop ticks per core period minus one, as a low-bit mask
  function automatic logic [PHASE_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = PHASE_W'((8'h01 << sel) - 8'h01);
  endfunction : div_mask
endpackage : clk_ctl_pkg

//--- logic/core_clock_divider.sv
/*
  Binary divider for the core clock enable. Counts loop clock ticks and
  pulses once per 2**sel ticks. Assumes loop_tick is a one-cycle pulse
  synchronous to pclk, one per loop clock period.
*/
module core_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic loop_tick,
  input wire logic [2:0] div_sel,
  output logic core_tick
);
  localparam int PHASE_W = clk_ctl_pkg::PHASE_W;

  typedef struct packed {
    logic [clk_ctl_pkg::PHASE_W-1:0] phase;
    logic [2:0] sel;
    logic tick;
  } div_state_t;

  localparam div_state_t DIV_RESET = '{
    phase: '0, sel: clk_ctl_pkg::DIV_DEFAULT, tick: 1'b0};

  div_state_t state_reg;
  div_state_t state_next;
  logic boundary;

  // new selection only taken at a period end; free-running phase can make the first new period short
  always_comb
  begin
    state_next = state_reg;
    boundary = loop_tick && ((state_reg.phase &
      clk_ctl_pkg::div_mask(state_reg.sel)) ==
      clk_ctl_pkg::div_mask(state_reg.sel));
    state_next.phase = state_reg.phase + PHASE_W'(loop_tick);
    state_next.tick = boundary;
    if (boundary)
    begin
      state_next.sel = div_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= DIV_RESET;
    else
      state_reg <= state_next;
  end

  assign core_tick = state_reg.tick;

  // selection only moves on the edge that starts a core period
  sel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.tick |-> $stable(state_reg.sel))
    else $error("divider select changed inside a core period");
endmodule : core_clock_divider

//--- logic/pll_core_clock_control.sv
/*
  Loop clock control: the control register on APB, core clock divider
  selection, fast interrupt override, modulator clock enable, oscillator
  power-down policy, lock status and latched external access level.
  Assumes the analog loop supplies loop_tick (one pulse per loop clock
  period) and lock_detect, both synchronous to pclk; the core supplies
  irq_active while servicing an interrupt and power_down in power-down.
*/
// Added by the designer: register access over APB.
// Overview of operation
// - loop runs at 384 times the crystal
// - core clock is loop divided by 2**code
// - after reset divider code is three
// - modulator clock at crystal rate, core aligned
// - read-only lock bit 6 shows tracking
// - bit 4 reads access pin caught at reset
// - fast-interrupt bit forces full speed in service
// - bit 7 halts oscillator in power-down
module pll_core_clock_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loop_tick,
  input wire logic lock_detect,
  input wire logic external_access_pin,
  input wire logic irq_active,
  input wire logic power_down,
  output logic core_clk_en,
  output logic mod_clk_en,
  output logic osc_enable
);
  typedef struct packed {
    logic [2:0] cd;
    logic fast_irq_full_speed;
    logic osc_halt_in_powerdown;
    logic lock;
    logic latched_ext_access_pin;
    logic pin_taken;
    logic written;
    logic [8:0] mod_cnt;
    logic mod_tick;
    logic osc_en;
    logic [2:0] sel;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{
    cd: clk_ctl_pkg::CTRL_RESET[clk_ctl_pkg::DIV_LSB +: clk_ctl_pkg::DIV_W],
    fast_irq_full_speed:
      clk_ctl_pkg::CTRL_RESET[clk_ctl_pkg::FAST_IRQ_BIT],
    osc_halt_in_powerdown:
      clk_ctl_pkg::CTRL_RESET[clk_ctl_pkg::OSC_HALT_BIT],
    lock: 1'b0,
    latched_ext_access_pin: 1'b0,
    pin_taken: 1'b0,
    written: 1'b0,
    mod_cnt: '0,
    mod_tick: 1'b0,
    osc_en: 1'b1,
    sel: clk_ctl_pkg::DIV_DEFAULT,
    rdata: '0,
    ready: 1'b0,
    err: 1'b0};

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic hit;
  logic setup;
  logic wr_take;
  logic [7:0] ctrl_view;
  logic core_tick;

  // bus decode; setup phase is psel with penable low
  assign hit = (paddr == clk_ctl_pkg::CTRL_ADDR);
  assign setup = psel && !penable;
  assign wr_take = psel && penable && state_reg.ready && pwrite && hit;

  // register image as software reads it; bit 5 reads zero
  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[clk_ctl_pkg::OSC_HALT_BIT] = state_reg.osc_halt_in_powerdown;
    ctrl_view[clk_ctl_pkg::LOCK_BIT] = state_reg.lock;
    ctrl_view[clk_ctl_pkg::LATCHED_PIN_BIT] =
      state_reg.latched_ext_access_pin;
    ctrl_view[clk_ctl_pkg::FAST_IRQ_BIT] = state_reg.fast_irq_full_speed;
    ctrl_view[clk_ctl_pkg::DIV_LSB +: clk_ctl_pkg::DIV_W] = state_reg.cd;
  end

  // all next-state logic of the block apart from the core divider
  always_comb
  begin
    state_next = state_reg;
    // zero wait states: answer is ready in every access phase
    state_next.ready = setup;
    state_next.err = setup && !hit;
    state_next.rdata = (setup && !pwrite && hit) ? {24'h000000, ctrl_view}
      : 32'h00000000;
    // lock and latched pin bits ignore writes
    if (wr_take)
    begin
      state_next.cd =
        pwdata[clk_ctl_pkg::DIV_LSB +: clk_ctl_pkg::DIV_W];
      state_next.fast_irq_full_speed =
        pwdata[clk_ctl_pkg::FAST_IRQ_BIT];
      state_next.osc_halt_in_powerdown =
        pwdata[clk_ctl_pkg::OSC_HALT_BIT];
      state_next.written = 1'b1;
    end
    state_next.lock = lock_detect;
    // pin level caught once, on the first edge after reset release
    if (!state_reg.pin_taken)
    begin
      state_next.latched_ext_access_pin = external_access_pin;
      state_next.pin_taken = 1'b1;
    end
    // full speed while an interrupt is serviced, if enabled
    state_next.sel = (state_reg.fast_irq_full_speed && irq_active) ?
      clk_ctl_pkg::DIV_FAST : state_reg.cd;
    // 384 loop ticks per crystal period; 384 is a multiple of every
    // divider so every modulator edge falls on a core edge
    state_next.mod_tick = loop_tick &&
      (state_reg.mod_cnt == clk_ctl_pkg::MOD_LAST);
    if (loop_tick)
    begin
      state_next.mod_cnt = (state_reg.mod_cnt == clk_ctl_pkg::MOD_LAST) ?
        9'h000 : state_reg.mod_cnt + 9'h001;
    end
    // oscillator stops only in power-down with the halt bit set
    state_next.osc_en =
      !(power_down && state_reg.osc_halt_in_powerdown);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= CTL_RESET;
    else
      state_reg <= state_next;
  end

  // divider keeps its own phase counter in step with mod_cnt
  core_clock_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .loop_tick(loop_tick),
    .div_sel(state_reg.sel),
    .core_tick(core_tick)
  );

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign core_clk_en = core_tick; // flop inside the divider
  assign mod_clk_en = state_reg.mod_tick;
  assign osc_enable = state_reg.osc_en;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence write_ctrl_s;
    psel && penable && pready && pwrite && hit;
  endsequence

  sequence read_setup_s;
    psel && !penable && !pwrite && hit;
  endsequence

  // first cycle after an interrupt service
  sequence service_end_s;
    irq_active ##1 !irq_active;
  endsequence

  // a write lands in the fields on the next cycle
  write_fields_a: assert property (
    write_ctrl_s |=> state_reg.cd == $past(pwdata[2:0]) &&
      state_reg.fast_irq_full_speed == $past(pwdata[3]))
    else $error("control write not stored");

  // untouched register keeps the default divider
  reset_divider_a: assert property (
    !state_reg.written |-> state_reg.cd == clk_ctl_pkg::DIV_DEFAULT)
    else $error("divider not at default after reset");

  // modulator edge always falls on a core edge
  mod_sync_a: assert property (
    mod_clk_en |-> core_clk_en)
    else $error("modulator and core clock out of step");

  // read of lock bit returns the loop state one cycle before setup
  lock_read_a: assert property (
    read_setup_s ##1 (psel && penable) |-> prdata[6] == $past(lock_detect, 2))
    else $error("lock bit read wrong");

  // latched pin never moves after capture
  pin_hold_a: assert property (
    state_reg.pin_taken |=> $stable(state_reg.latched_ext_access_pin))
    else $error("latched access pin changed");

  // override active in service, released after return
  fast_irq_a: assert property (
    state_reg.fast_irq_full_speed && irq_active |=>
      state_reg.sel == clk_ctl_pkg::DIV_FAST)
    else $error("fast interrupt override missing");

  irq_release_a: assert property (
    service_end_s |=> state_reg.sel == $past(state_reg.cd))
    else $error("divider not restored after service");

  // oscillator policy follows power-down and halt bit
  osc_policy_a: assert property (
    power_down && state_reg.osc_halt_in_powerdown |=> !osc_enable)
    else $error("oscillator not halted in power-down");

  osc_keep_a: assert property (
    !state_reg.osc_halt_in_powerdown |=> osc_enable)
    else $error("oscillator stopped with halt bit clear");

  // unmapped address answers with an error
  bus_error_a: assert property (
    psel && !penable && !hit |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : pll_core_clock_control

//--- verification/loop_source.sv
/*
  Model of the analog loop beside the clock control block: loop clock
  ticks and the lock level. Assumes pclk is at least as fast as the loop clock.
*/
module loop_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic track,
  output logic loop_tick,
  output logic lock_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;

  // slow halves the tick rate, like a loop still pulling in
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 1'b0;
      loop_tick <= 1'b0;
      lock_detect <= 1'b0;
    end
    else
    begin
      ph <= ~ph;
      loop_tick <= slow ? ph : 1'b1;
      lock_detect <= track;
    end
  end
endmodule : loop_source

//--- verification/pll_core_clock_control_bench.sv
/*
  Bench for the loop clock control block: APB tasks, register and clock
  enable checks. Assumes loop_source drives the loop side, 50 MHz pclk.
*/
module pll_core_clock_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A = clk_ctl_pkg::CTRL_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, n;
  logic loop_tick, lock_detect, access_pin, irq, pdown, slow, track;
  logic core_clk_en, mod_clk_en, osc_enable;
  int n_errors, checked;

  pll_core_clock_control dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_tick(loop_tick), .lock_detect(lock_detect),
    .external_access_pin(access_pin), .irq_active(irq), .power_down(pdown),
    .core_clk_en(core_clk_en), .mod_clk_en(mod_clk_en),
    .osc_enable(osc_enable));
  loop_source src_u (.pclk(pclk), .presetn(presetn), .slow(slow),
    .track(track), .loop_tick(loop_tick), .lock_detect(lock_detect));

  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // setup then access; request held until pready seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    // data taken at the very edge that saw pready, then released
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask : apb

  // cycles until the next enable pulse, seen at rising edges so the
  // bench can drive inputs right after it returns
  task automatic pulse(input logic m, output logic [31:0] c);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while ((m ? mod_clk_en : core_clk_en) !== 1'b1 && c < 2000);
    if (c >= 2000)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask : pulse

  // old-period pulses, adoption and one partial period pass first
  task automatic period(output logic [31:0] c);
    repeat (4) pulse(1'b0, c);
    pulse(1'b0, c);
  endtask : period

  initial
  begin
    {psel, penable, pwrite, irq, pdown, slow} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    access_pin = 1'b1;
    track = 1'b1;
    presetn = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    access_pin <= 1'b0;
    apb(1'b0, A, 32'h0);
    chk(r, 32'h00000053);
    chk(osc_enable, 32'h1);
    pulse(1'b1, n);
    pulse(1'b1, n);
    chk(n, 32'h00000180);
    chk(core_clk_en, 32'h1);
    $display("reset and modulator test done");
    for (int cd = 0; cd < 8; cd++)
    begin
      apb(1'b1, A, 32'(cd));
      period(n);
      chk(n, 32'h1 << cd);
    end
    slow <= 1'b1;
    apb(1'b1, A, 32'h1);
    period(n);
    chk(n, 32'h4);
    slow <= 1'b0;
    $display("divider test done");
    apb(1'b1, A, 32'hFFFFFFFF);
    apb(1'b0, A, 32'h0);
    chk(r, 32'h000000DF);
    irq <= 1'b1;
    period(n);
    chk(n, 32'h1);
    irq <= 1'b0;
    period(n);
    chk(n, 32'h80);
    pdown <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(osc_enable, 32'h0);
    apb(1'b1, A, 32'h3);
    repeat (3) @(posedge pclk);
    chk(osc_enable, 32'h1);
    pdown <= 1'b0;
    track <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, A, 32'h0);
    chk(r, 32'h00000013);
    apb(1'b0, 12'h000, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    $display("control bits test done");
    // second reset: pin now low, loop not tracking, divider back to 3
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A, 32'h0);
    chk(r, 32'h00000003);
    $display("second reset test done");
    report_and_stop();
  end
endmodule : pll_core_clock_control_bench
